// File: hdl/hssc_pkg.sv
/*
  Package for the high-side switch control block: register offsets, field
  layouts, reset values, mode and channel-configuration codes, and the
  timing constants derived from the 25 MHz system clock.
  Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
package hssc_pkg;

  // ---------------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned PWM_FAST_HZ = 400;
  localparam int unsigned PWM_SLOW_HZ = 200;
  localparam int unsigned PWM_STEPS = 256;
  // Step length in clocks; rounded down so the period never overshoots.
  localparam int unsigned PWM_FAST_STEP_CYC = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
  localparam int unsigned PWM_SLOW_STEP_CYC = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
  // Open-load filter, 64 us typical; least time so rounded up.
  localparam int unsigned OL_FILTER_NS = 64000;
  localparam int unsigned OL_FILTER_CYC = (OL_FILTER_NS * 25 + 999) / 1000;
  // Overcurrent filter, 16 us typical; least time so rounded up.
  localparam int unsigned OC_FILTER_NS = 16000;
  localparam int unsigned OC_FILTER_CYC = (OC_FILTER_NS * 25 + 999) / 1000;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] SWITCH_CONFIG_A_OFS = 8'h00;
  localparam logic [7:0] SWITCH_CONFIG_B_OFS = 8'h04;
  localparam logic [7:0] SUPPLY_CTRL_OFS = 8'h08;
  localparam logic [7:0] DUTY_GEN1_OFS = 8'h0c;
  localparam logic [7:0] DUTY_GEN2_OFS = 8'h10;
  localparam logic [7:0] PWM_FREQ_OFS = 8'h14;
  localparam logic [7:0] OVERCURRENT_STAT_OFS = 8'h18;
  localparam logic [7:0] OPEN_LOAD_STAT_OFS = 8'h1c;
  localparam logic [7:0] SUPPLY_STAT_OFS = 8'h20;
  localparam logic [7:0] MODE_OFS = 8'h24;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned CFG_W = 3;
  localparam int unsigned CFG_LO_POS = 0; // First channel of a config register.
  localparam int unsigned CFG_HI_POS = 4; // Second channel of a config register.
  localparam int unsigned OV_SD_EN_POS = 0;
  localparam int unsigned UV_SD_EN_POS = 1;
  localparam int unsigned RECOVERY_POS = 2;
  localparam int unsigned OV_FLAG_POS = 0;
  localparam int unsigned UV_FLAG_POS = 1;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [2:0] SUPPLY_CTRL_RESET = 3'h0;
  localparam logic [1:0] PWM_FREQ_RESET = 2'h0; // 0 = 200 Hz, 1 = 400 Hz.

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    HSSC_CFG_OFF = 3'b000,
    HSSC_CFG_ON = 3'b001,
    HSSC_CFG_TIMER1 = 3'b010,
    HSSC_CFG_TIMER2 = 3'b011,
    HSSC_CFG_PWM1 = 3'b100,
    HSSC_CFG_PWM2 = 3'b101
  } hssc_cfg_t;

  typedef enum logic [2:0] {
    HSSC_MODE_NORMAL = 3'b000,
    HSSC_MODE_STOP = 3'b001,
    HSSC_MODE_SLEEP = 3'b010,
    HSSC_MODE_RESTART = 3'b011,
    HSSC_MODE_FAILSAFE = 3'b100
  } hssc_mode_t;

  // Per-channel analog sense inputs travel together.
  typedef struct packed {
    logic [3:0] overcurrent;
    logic [3:0] undercurrent;
  } hssc_sense_t;

  // Supply comparator results.
  typedef struct packed {
    logic overvoltage;
    logic undervoltage;
  } hssc_supply_t;

endpackage

// File: hdl/hssc_top.sv
/*
  High-side switch control: four load switch outputs driven directly, by
  two external timers or by two 8-bit PWM generators, with supply, overcurrent
  and open-load protection and an AXI4-Lite register slave.
  Assumes the comparator, timer and mode inputs are synchronous to aclk.
*/
// Chosen here: the placing of the registers and the AXI4-Lite register port.
// Contract
// RULE1: Configuration writable only in normal mode.
// RULE2: Restart or fail-safe entry turns outputs off.
// RULE3: Software may re-enable outputs after failure.
// RULE4: Overvoltage turns drivers off unless disabled.
// RULE5: Undervoltage turns drivers off unless disabled.
// RULE6: Recovery bit restores, else clears configuration.
// RULE7: Supply faults only set supply flags.
// RULE8: Filtered overcurrent switches the output off.
// RULE9: Overcurrent sets flag, clears configuration field.
// RULE10: Software reactivates by writing on or timer.
// RULE11: Overcurrent flags stay until software clears.
// RULE12: Open load sets flag, output stays on.
// RULE13: Open-load flags clear only when condition gone.
// RULE14: Protection and PWM keep working in low power.
// RULE15: Two generators, each own 8-bit duty.
// RULE16: Each generator 200 or 400 Hz.
// RULE17: Outputs direct, timer or PWM controlled.
// RULE18: PWM drives immediately once assigned.
// RULE19: Duty one is not realisable by switch.
// RULE20: Duty floor for reliable open-load detection.
// RULE21: Duty floor for reliable overcurrent detection.
// RULE22: Open load filtered 64 us before flag.
// RULE23: Period has 256 steps, duty steps on.
`timescale 1ns/1ps

module hssc_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device mode and timers
  input wire hssc_pkg::hssc_mode_t device_mode,
  input wire logic timer1_out,
  input wire logic timer2_out,
  // Analog comparators
  input wire hssc_pkg::hssc_supply_t supply_cmp,
  input wire hssc_pkg::hssc_sense_t sense_cmp,
  // Switch drive
  output logic [3:0] load_switch_output
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [2:0] cfg_reg [4];
  logic [7:0] duty_reg [2];
  logic [1:0] pwm_freq_reg;
  logic [2:0] supply_ctrl_reg;
  logic [3:0] oc_flag_reg;
  logic [3:0] ol_flag_reg;
  logic [1:0] supply_flag_reg;
  logic [3:0] out_reg;
  logic [7:0] pwm_step_reg [2];
  logic [15:0] pwm_div_reg [2];
  logic [1:0] pwm_out;
  logic [9:0] oc_cnt_reg [4];
  logic [11:0] ol_cnt_reg [4];
  logic supply_fault_q_reg;
  logic forced_off_reg;
  logic aw_held_reg, w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic normal_mode;
  logic ov_active, uv_active, supply_fault;
  logic [3:0] oc_trip;
  logic [3:0] want_on;

  // Decodes the output level a channel configuration asks for.
  function automatic logic cfg_level(input logic [2:0] cfg, input logic t1, input logic t2,
                                     input logic [1:0] pwm);
    unique case (hssc_pkg::hssc_cfg_t'(cfg))
      hssc_pkg::HSSC_CFG_ON: cfg_level = 1'b1;
      hssc_pkg::HSSC_CFG_TIMER1: cfg_level = t1;
      hssc_pkg::HSSC_CFG_TIMER2: cfg_level = t2;
      hssc_pkg::HSSC_CFG_PWM1: cfg_level = pwm[0];
      hssc_pkg::HSSC_CFG_PWM2: cfg_level = pwm[1];
      default: cfg_level = 1'b0; // Off and unused codes.
    endcase
  endfunction

  // Returns true when a write hits the given byte offset with lane 0 enabled.
  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] ofs,
                                  input logic [3:0] strb);
    wr_hit = (addr == ofs) && strb[0];
  endfunction

  // ---------------------------------------------------------------------------
  // Mode and supply conditions
  // ---------------------------------------------------------------------------
  // Low-power modes keep the last configuration except for hardware clears; only normal mode may write it.
  assign normal_mode = (device_mode == hssc_pkg::HSSC_MODE_NORMAL); // [RULE1]
  assign ov_active = supply_cmp.overvoltage && !supply_ctrl_reg[hssc_pkg::OV_SD_EN_POS]; // [RULE4]
  assign uv_active = supply_cmp.undervoltage && !supply_ctrl_reg[hssc_pkg::UV_SD_EN_POS]; // [RULE5]
  assign supply_fault = ov_active || uv_active;

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  // Address and data are latched independently so either may arrive first.
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_rresp = 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data is registered; unmapped addresses read as zero with OKAY.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      unique case ({s_axi_araddr[7:2], 2'b00})
        hssc_pkg::SWITCH_CONFIG_A_OFS: s_axi_rdata <= {25'h0, cfg_reg[1], 1'b0, cfg_reg[0]};
        hssc_pkg::SWITCH_CONFIG_B_OFS: s_axi_rdata <= {25'h0, cfg_reg[3], 1'b0, cfg_reg[2]};
        hssc_pkg::SUPPLY_CTRL_OFS: s_axi_rdata <= {29'h0, supply_ctrl_reg};
        hssc_pkg::DUTY_GEN1_OFS: s_axi_rdata <= {24'h0, duty_reg[0]};
        hssc_pkg::DUTY_GEN2_OFS: s_axi_rdata <= {24'h0, duty_reg[1]};
        hssc_pkg::PWM_FREQ_OFS: s_axi_rdata <= {30'h0, pwm_freq_reg};
        hssc_pkg::OVERCURRENT_STAT_OFS: s_axi_rdata <= {28'h0, oc_flag_reg};
        hssc_pkg::OPEN_LOAD_STAT_OFS: s_axi_rdata <= {28'h0, ol_flag_reg};
        hssc_pkg::SUPPLY_STAT_OFS: s_axi_rdata <= {30'h0, supply_flag_reg};
        hssc_pkg::MODE_OFS: s_axi_rdata <= {29'h0, device_mode};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------------
  // A hardware clear wins over a software write in the same cycle, so a trip
  // is never masked by a write that raced it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) cfg_reg[i] <= hssc_pkg::HSSC_CFG_OFF;
      duty_reg[0] <= hssc_pkg::DUTY_RESET;
      duty_reg[1] <= hssc_pkg::DUTY_RESET;
      pwm_freq_reg <= hssc_pkg::PWM_FREQ_RESET;
      supply_ctrl_reg <= hssc_pkg::SUPPLY_CTRL_RESET;
    end else begin
      if (wr_fire && normal_mode) begin // [RULE1] [RULE3] [RULE10]
        if (wr_hit(aw_addr_reg, hssc_pkg::SWITCH_CONFIG_A_OFS, w_strb_reg)) begin
          cfg_reg[0] <= w_data_reg[hssc_pkg::CFG_LO_POS +: hssc_pkg::CFG_W];
          cfg_reg[1] <= w_data_reg[hssc_pkg::CFG_HI_POS +: hssc_pkg::CFG_W];
        end
        if (wr_hit(aw_addr_reg, hssc_pkg::SWITCH_CONFIG_B_OFS, w_strb_reg)) begin
          cfg_reg[2] <= w_data_reg[hssc_pkg::CFG_LO_POS +: hssc_pkg::CFG_W];
          cfg_reg[3] <= w_data_reg[hssc_pkg::CFG_HI_POS +: hssc_pkg::CFG_W];
        end
        if (wr_hit(aw_addr_reg, hssc_pkg::SUPPLY_CTRL_OFS, w_strb_reg))
          supply_ctrl_reg <= w_data_reg[2:0];
        if (wr_hit(aw_addr_reg, hssc_pkg::DUTY_GEN1_OFS, w_strb_reg))
          duty_reg[0] <= w_data_reg[7:0]; // [RULE15]
        if (wr_hit(aw_addr_reg, hssc_pkg::DUTY_GEN2_OFS, w_strb_reg))
          duty_reg[1] <= w_data_reg[7:0]; // [RULE15]
        if (wr_hit(aw_addr_reg, hssc_pkg::PWM_FREQ_OFS, w_strb_reg))
          pwm_freq_reg <= w_data_reg[1:0]; // [RULE16]
      end
      for (int i = 0; i < 4; i++) begin
        if (oc_trip[i]) cfg_reg[i] <= hssc_pkg::HSSC_CFG_OFF; // [RULE9]
        // Without recovery, clearing the fault leaves the switches off.
        if (supply_fault_q_reg && !supply_fault && !supply_ctrl_reg[hssc_pkg::RECOVERY_POS])
          cfg_reg[i] <= hssc_pkg::HSSC_CFG_OFF; // [RULE6]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------------------
  // Write one to clear; a new event in the same cycle keeps the flag set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_flag_reg <= 4'h0;
      ol_flag_reg <= 4'h0;
      supply_flag_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (oc_trip[i]) oc_flag_reg[i] <= 1'b1; // [RULE9]
        else if (wr_fire && wr_hit(aw_addr_reg, hssc_pkg::OVERCURRENT_STAT_OFS, w_strb_reg)
                 && w_data_reg[i])
          oc_flag_reg[i] <= 1'b0; // [RULE11]
        if (ol_cnt_reg[i] == 12'(hssc_pkg::OL_FILTER_CYC)) ol_flag_reg[i] <= 1'b1; // [RULE22]
        else if (wr_fire && wr_hit(aw_addr_reg, hssc_pkg::OPEN_LOAD_STAT_OFS, w_strb_reg)
                 && w_data_reg[i] && !(out_reg[i] && sense_cmp.undercurrent[i]))
          ol_flag_reg[i] <= 1'b0; // [RULE13]
      end
      // Supply faults touch only these two flags. [RULE7]
      if (ov_active) supply_flag_reg[hssc_pkg::OV_FLAG_POS] <= 1'b1;
      else if (wr_fire && wr_hit(aw_addr_reg, hssc_pkg::SUPPLY_STAT_OFS, w_strb_reg)
               && w_data_reg[hssc_pkg::OV_FLAG_POS])
        supply_flag_reg[hssc_pkg::OV_FLAG_POS] <= 1'b0;
      if (uv_active) supply_flag_reg[hssc_pkg::UV_FLAG_POS] <= 1'b1;
      else if (wr_fire && wr_hit(aw_addr_reg, hssc_pkg::SUPPLY_STAT_OFS, w_strb_reg)
               && w_data_reg[hssc_pkg::UV_FLAG_POS])
        supply_flag_reg[hssc_pkg::UV_FLAG_POS] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // PWM generators
  // ---------------------------------------------------------------------------
  // Free-running in every mode so low-power PWM keeps going. [RULE14] [RULE23]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int g = 0; g < 2; g++) begin
        pwm_div_reg[g] <= 16'h0000;
        pwm_step_reg[g] <= 8'h00;
      end
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (pwm_div_reg[g] == (pwm_freq_reg[g] ? 16'(hssc_pkg::PWM_FAST_STEP_CYC - 1)
                                               : 16'(hssc_pkg::PWM_SLOW_STEP_CYC - 1))) begin
          pwm_div_reg[g] <= 16'h0000;
          pwm_step_reg[g] <= pwm_step_reg[g] + 8'h01; // [RULE16]
        end else begin
          pwm_div_reg[g] <= pwm_div_reg[g] + 16'h0001;
        end
      end
    end
  end

  // On for as many of the 256 steps as the duty value says. [RULE15]
  assign pwm_out[0] = pwm_step_reg[0] < duty_reg[0];
  assign pwm_out[1] = pwm_step_reg[1] < duty_reg[1];

  // ---------------------------------------------------------------------------
  // Protection filters
  // ---------------------------------------------------------------------------
  // Counters restart whenever the output is off, so a trip needs a continuous
  // on-time longer than the filter; short PWM pulses cannot trip.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        oc_cnt_reg[i] <= 10'h000;
        ol_cnt_reg[i] <= 12'h000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (out_reg[i] && sense_cmp.overcurrent[i] && !oc_trip[i])
          oc_cnt_reg[i] <= oc_cnt_reg[i] + 10'h001; // [RULE8]
        else
          oc_cnt_reg[i] <= 10'h000;
        if (out_reg[i] && sense_cmp.undercurrent[i]) begin
          if (ol_cnt_reg[i] != 12'(hssc_pkg::OL_FILTER_CYC))
            ol_cnt_reg[i] <= ol_cnt_reg[i] + 12'h001; // [RULE12]
        end else begin
          ol_cnt_reg[i] <= 12'h000;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++)
      oc_trip[i] = oc_cnt_reg[i] == 10'(hssc_pkg::OC_FILTER_CYC); // [RULE8]
  end

  // ---------------------------------------------------------------------------
  // Output drive
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_fault_q_reg <= 1'b0;
      forced_off_reg <= 1'b0;
    end else begin
      supply_fault_q_reg <= supply_fault;
      forced_off_reg <= (device_mode == hssc_pkg::HSSC_MODE_RESTART)
                        || (device_mode == hssc_pkg::HSSC_MODE_FAILSAFE);
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++)
      want_on[i] = cfg_level(cfg_reg[i], timer1_out, timer2_out, pwm_out); // [RULE17] [RULE18]
  end

  // Open load leaves it on; a fault's final cycle stays off so a cleared config cannot glitch.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg <= 4'h0;
    end else if (forced_off_reg || (device_mode == hssc_pkg::HSSC_MODE_RESTART)
                 || (device_mode == hssc_pkg::HSSC_MODE_FAILSAFE)) begin
      out_reg <= 4'h0; // [RULE2]
    end else begin
      out_reg <= (supply_fault || supply_fault_q_reg) ? 4'h0 : (want_on & ~oc_trip); // [RULE6]
    end
  end

  assign load_switch_output = out_reg;

endmodule

// File: verification/hssc_chk.sv
/* Assertions on bus handshakes and protection timing.
   Assumes it is bound to hssc_top and sees its ports only. */
`timescale 1ns/1ps
module hssc_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Mode, sense and drive
  input wire hssc_pkg::hssc_mode_t device_mode,
  input wire hssc_pkg::hssc_sense_t sense_cmp,
  input wire logic [3:0] load_switch_output
);
  localparam int OC_LIMIT = hssc_pkg::OC_FILTER_CYC + 3;
  int oc_run_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Cycles channel one is on into an overcurrent.
  always_ff @(posedge aclk) begin
    if (!aresetn || !(load_switch_output[0] && sense_cmp.overcurrent[0])) begin
      oc_run_reg <= 0;
    end else begin
      oc_run_reg <= oc_run_reg + 1;
    end
  end
  property p_bresp_okay; s_axi_bvalid |-> s_axi_bresp == 2'h0; endproperty
  a_bresp_okay: assert property (p_bresp_okay) else $error("bresp not okay");
  property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("rdata not held");
  property p_no_take_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_no_take_busy: assert property (p_no_take_busy) else $error("taken while busy");
  property p_write_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no bvalid");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp == 2'h0;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("no rvalid");
  property p_forced_off;
    device_mode == hssc_pkg::HSSC_MODE_RESTART || device_mode == hssc_pkg::HSSC_MODE_FAILSAFE
      |=> load_switch_output == 4'h0;
  endproperty
  a_forced_off: assert property (p_forced_off) else $error("output not off");
  property p_oc_trip; oc_run_reg <= OC_LIMIT; endproperty
  a_oc_trip: assert property (p_oc_trip) else $error("no oc trip");
  c_write: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_restart: cover property (device_mode == hssc_pkg::HSSC_MODE_RESTART);
  c_oc: cover property (oc_run_reg == hssc_pkg::OC_FILTER_CYC);
endmodule
bind hssc_top hssc_chk i_hssc_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .device_mode,
  .sense_cmp, .load_switch_output);

// File: verification/hssc_top_tb.sv
/* Self-checking bench for hssc_top over its register bus.
   Assumes the package constants and a 25 MHz clock. */
`timescale 1ns/1ps
module hssc_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] lso;
  hssc_pkg::hssc_mode_t mode = hssc_pkg::HSSC_MODE_NORMAL;
  logic t1 = 1'b0, t2 = 1'b0;
  hssc_pkg::hssc_supply_t supply = 2'b00;
  hssc_pkg::hssc_sense_t sense = 8'h00;
  int errors = 0;
  int samples_checked = 0;
  int n;
  localparam logic [7:0] CFG_A = hssc_pkg::SWITCH_CONFIG_A_OFS;
  localparam logic [7:0] CFG_B = hssc_pkg::SWITCH_CONFIG_B_OFS;
  localparam logic [7:0] OC_ST = hssc_pkg::OVERCURRENT_STAT_OFS;
  localparam logic [7:0] OL_ST = hssc_pkg::OPEN_LOAD_STAT_OFS;
  localparam logic [7:0] SUP_ST = hssc_pkg::SUPPLY_STAT_OFS;
  hssc_top i_hssc_top (.aclk, .aresetn, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .device_mode(mode), .timer1_out(t1), .timer2_out(t2),
    .supply_cmp(supply), .sense_cmp(sense), .load_switch_output(lso));
  // Free-running 25 MHz clock.
  always #20 aclk = ~aclk;
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic stuck(input string m);
    errors++;
    $display("unexpected at %0t: %s timed out", $time, m);
    wrap_up();
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask
  // AW and W go out together; each drops when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    logic done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && k < 50) begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) stuck("write");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    int k = 0;
    logic done = 1'b0;
    logic [31:0] got = 32'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && k < 50) begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = rdata;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) stuck("read");
    check(got, exp, m);
  endtask
  // Outputs lag their cause by up to two cycles.
  task automatic out(input logic [3:0] exp, input string m);
    cyc(3);
    check({28'h0, lso}, {28'h0, exp}, m);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    cyc(6);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++) rd(8'(i * 4), 32'h0, "reset value");
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h0, "unmapped");
    $display("reset test done");
    t1 <= 1'b1;
    wr(CFG_A, 32'h21);
    wr(CFG_B, 32'h30);
    out(4'b0011, "direct and timer1");
    t1 <= 1'b0;
    t2 <= 1'b1;
    out(4'b1001, "timer2");
    mode <= hssc_pkg::HSSC_MODE_STOP;
    wr(CFG_A, 32'h0);
    rd(CFG_A, 32'h21, "config locked");
    out(4'b1001, "kept in stop");
    rd(hssc_pkg::MODE_OFS, 32'h1, "mode");
    mode <= hssc_pkg::HSSC_MODE_RESTART;
    out(4'b0000, "restart off");
    mode <= hssc_pkg::HSSC_MODE_FAILSAFE;
    out(4'b0000, "failsafe off");
    mode <= hssc_pkg::HSSC_MODE_NORMAL;
    wr(CFG_A, 32'h11);
    wr(CFG_B, 32'h0);
    out(4'b0011, "re-enabled");
    $display("mode test done");
    supply <= 2'b10;
    out(4'b0000, "overvoltage off");
    rd(SUP_ST, 32'h1, "ov flag");
    rd(OC_ST, 32'h0, "no oc flag");
    rd(OL_ST, 32'h0, "no ol flag");
    supply <= 2'b00;
    out(4'b0000, "no recovery");
    rd(CFG_A, 32'h0, "config cleared");
    wr(SUP_ST, 32'h3);
    rd(SUP_ST, 32'h0, "supply clear");
    wr(hssc_pkg::SUPPLY_CTRL_OFS, 32'h4);
    wr(CFG_A, 32'h11);
    supply <= 2'b01;
    out(4'b0000, "undervoltage off");
    supply <= 2'b00;
    out(4'b0011, "recovered");
    wr(hssc_pkg::SUPPLY_CTRL_OFS, 32'h5);
    supply <= 2'b10;
    out(4'b0011, "ov shutdown disabled");
    supply <= 2'b00;
    wr(SUP_ST, 32'h3);
    $display("supply test done");
    sense <= 8'h10;
    n = 0;
    while (lso[0] && n < 600) begin
      @(posedge aclk);
      n++;
    end
    if (n == 600) stuck("oc trip");
    check(32'(n >= hssc_pkg::OC_FILTER_CYC && n <= hssc_pkg::OC_FILTER_CYC + 4), 32'h1,
      "oc filter");
    out(4'b0010, "oc off");
    rd(CFG_A, 32'h10, "oc config");
    sense <= 8'h00;
    rd(OC_ST, 32'h1, "oc sticky");
    wr(OC_ST, 32'h1);
    rd(OC_ST, 32'h0, "oc clear");
    wr(CFG_A, 32'h11);
    out(4'b0011, "oc reactivated");
    $display("overcurrent test done");
    sense <= 8'h01;
    cyc(hssc_pkg::OL_FILTER_CYC - 100);
    rd(OL_ST, 32'h0, "ol filtering");
    cyc(200);
    rd(OL_ST, 32'h1, "ol flag");
    out(4'b0011, "ol stays on");
    wr(OL_ST, 32'h1);
    rd(OL_ST, 32'h1, "ol clear refused");
    sense <= 8'h00;
    wr(OL_ST, 32'h1);
    rd(OL_ST, 32'h0, "ol cleared");
    $display("open load test done");
    wr(hssc_pkg::DUTY_GEN1_OFS, 32'h0);
    wr(hssc_pkg::DUTY_GEN2_OFS, 32'hff);
    wr(hssc_pkg::PWM_FREQ_OFS, 32'h3);
    rd(hssc_pkg::DUTY_GEN2_OFS, 32'hff, "duty");
    rd(hssc_pkg::PWM_FREQ_OFS, 32'h3, "freq");
    wr(CFG_B, 32'h54);
    n = 0;
    while (!lso[3] && n < 1000) begin
      @(posedge aclk);
      n++;
    end
    check(32'(n < 1000), 32'h1, "pwm starts");
    check({31'h0, lso[2]}, 32'h0, "duty zero off");
    $display("pwm test done");
    wrap_up();
  end
endmodule
